/* hw/dtd_decode.sv */
// Purpose: Decode, clock count and exception check for data transfer forms
// Assumes: One instruction offered per cycle, context valid with it
// Notes:   Result appears one cycle after the instruction is taken
// What this block does
// RULE1 - 8C copies segment register to reg or memory; 2 or 3 clocks.
// RULE2 - C5 memory-only loads far pointer, offset to register, selector data segment.
// RULE3 - C4 memory loads far pointer into register and extra segment; 7/21.
// RULE4 - 9F copies flag low byte into accumulator high byte; 2 clocks.
// RULE5 - D7 loads accumulator low from table base plus low; 5 clocks.
// RULE6 - 8D writes effective offset to register, no memory access, 3 clocks.
// RULE7 - Clock count looked up by form, operand kind and mode.
// RULE8 - Real mode word operand at offset FFFF raises overrun vector 13.
// RULE9 - Protected limit or rights fault gives 13; stack limit gives 12.
// RULE10 - Protected segment load of absent descriptor gives 11, or 12 for stack.
// RULE11 - Protected port access with privilege above threshold gives 13.
`timescale 1ns/1ps
`default_nettype none
`include "dtd_defs.svh"

module dtd_decode (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               instr_valid,
    input  wire dtd_pkg::dtd_instr_t instr,
    input  wire dtd_pkg::dtd_ctx_t   ctx,
    output var  dtd_pkg::dtd_result_t result
);

    dtd_pkg::dtd_result_t result_reg;
    dtd_pkg::dtd_result_t result_next;

    logic [1:0] mode_field;
    logic [2:0] reg_field;
    logic       is_mem;
    logic       word_op;
    logic       seg_load;
    logic       seg_dest_ss;
    logic       io_form;
    logic       mem_access;
    logic       bad_mod;

    assign mode_field = instr.operand[7:6];
    assign reg_field  = instr.operand[5:3];
    assign is_mem     = (mode_field != `DTD_MOD_REG);

    always_comb
    begin
        result_next = '0;
        word_op     = 1'b1;
        seg_load    = 1'b0;
        seg_dest_ss = 1'b0;
        io_form     = 1'b0;
        mem_access  = 1'b0;
        bad_mod     = 1'b0;
        if (instr_valid)
        begin
            result_next.valid          = 1'b1;
            result_next.memory_operand = 1'b0;
            if (instr.opcode == `DTD_OP_RM_TO_SEG)
            begin
                result_next.form           = dtd_pkg::DTD_FORM_RM_TO_SEG;
                result_next.memory_operand = is_mem;
                seg_load                   = 1'b1;
                seg_dest_ss                = (reg_field[1:0] == `DTD_SEG_SS);
            end
            else if (instr.opcode == `DTD_OP_SEG_TO_RM)
            begin
                result_next.form           = dtd_pkg::DTD_FORM_SEG_TO_RM; // RULE1
                result_next.memory_operand = is_mem; // RULE1
            end
            else if (instr.opcode == `DTD_OP_GRP_FF && reg_field == `DTD_REG_PUSH)
            begin
                result_next.form           = dtd_pkg::DTD_FORM_PUSH_MEM;
                result_next.memory_operand = is_mem;
            end
            else if (instr.opcode == `DTD_OP_POP_MEM && reg_field == `DTD_REG_POP)
            begin
                result_next.form           = dtd_pkg::DTD_FORM_POP_MEM;
                result_next.memory_operand = is_mem;
            end
            else if (instr.opcode[7:3] == `DTD_OP_PUSH_REG)
                result_next.form = dtd_pkg::DTD_FORM_PUSH_REG;
            else if (instr.opcode[7:3] == `DTD_OP_POP_REG)
                result_next.form = dtd_pkg::DTD_FORM_POP_REG;
            else if (instr.opcode[7:5] == 3'h0 && instr.opcode[2:0] == 3'h6)
                result_next.form = dtd_pkg::DTD_FORM_PUSH_SEG;
            else if (instr.opcode[7:5] == 3'h0 && instr.opcode[2:0] == 3'h7
                     && instr.opcode[4:3] != `DTD_SEG_CS)
            begin
                result_next.form = dtd_pkg::DTD_FORM_POP_SEG;
                seg_load         = 1'b1;
                seg_dest_ss      = (instr.opcode[4:3] == `DTD_SEG_SS);
            end
            else if ((instr.opcode & 8'hFD) == `DTD_OP_PUSH_IMM)
                result_next.form = dtd_pkg::DTD_FORM_PUSH_IMM;
            else if (instr.opcode == `DTD_OP_PUSHA)
                result_next.form = dtd_pkg::DTD_FORM_PUSHA;
            else if (instr.opcode == `DTD_OP_POPA)
                result_next.form = dtd_pkg::DTD_FORM_POPA;
            else if (instr.opcode[7:1] == `DTD_OP_XCHG_RM)
            begin
                result_next.form           = dtd_pkg::DTD_FORM_XCHG_RM;
                result_next.memory_operand = is_mem;
                word_op                    = instr.opcode[0];
            end
            else if (instr.opcode[7:3] == `DTD_OP_XCHG_ACC)
                result_next.form = dtd_pkg::DTD_FORM_XCHG_ACC;
            else if (instr.opcode[7:1] == `DTD_OP_IN_FIXED)
            begin
                result_next.form = dtd_pkg::DTD_FORM_IN_FIXED;
                io_form          = 1'b1;
            end
            else if (instr.opcode[7:1] == `DTD_OP_IN_VAR)
            begin
                result_next.form = dtd_pkg::DTD_FORM_IN_VAR;
                io_form          = 1'b1;
            end
            else if (instr.opcode[7:1] == `DTD_OP_OUT_FIXED)
            begin
                result_next.form = dtd_pkg::DTD_FORM_OUT_FIXED;
                io_form          = 1'b1;
            end
            else if (instr.opcode[7:1] == `DTD_OP_OUT_VAR)
            begin
                result_next.form = dtd_pkg::DTD_FORM_OUT_VAR;
                io_form          = 1'b1;
            end
            else if (instr.opcode == `DTD_OP_TRANSLATE)
            begin
                result_next.form       = dtd_pkg::DTD_FORM_TRANSLATE; // RULE5
                result_next.dest       = dtd_pkg::DTD_DEST_ACC_LOW; // RULE5
                result_next.mem_read   = 1'b1; // RULE5
                result_next.mem_offset = ctx.table_base
                                         + {8'h00, ctx.accumulator[7:0]}; // RULE5
                word_op                = 1'b0;
                mem_access             = 1'b1;
            end
            else if (instr.opcode == `DTD_OP_LOAD_EA)
            begin
                // Address only, so no segment check can apply
                result_next.form       = dtd_pkg::DTD_FORM_LOAD_EA; // RULE6
                result_next.dest       = dtd_pkg::DTD_DEST_GENERAL; // RULE6
                result_next.dest_index = reg_field; // RULE6
                result_next.data       = ctx.ea_offset; // RULE6
                bad_mod                = !is_mem;
            end
            else if (instr.opcode == `DTD_OP_FAR_DATA || instr.opcode == `DTD_OP_FAR_EXTRA)
            begin
                result_next.form       = (instr.opcode == `DTD_OP_FAR_DATA)
                                         ? dtd_pkg::DTD_FORM_FAR_DATA
                                         : dtd_pkg::DTD_FORM_FAR_EXTRA; // RULE2 RULE3
                result_next.memory_operand = 1'b1;
                result_next.dest       = dtd_pkg::DTD_DEST_GENERAL; // RULE2 RULE3
                result_next.dest_index = reg_field;
                result_next.mem_read   = is_mem;
                result_next.mem_offset = ctx.ea_offset;
                seg_load               = 1'b1;
                bad_mod                = !is_mem; // RULE2 RULE3
            end
            else if (instr.opcode == `DTD_OP_FLAGS_ACC)
            begin
                result_next.form = dtd_pkg::DTD_FORM_FLAGS_ACC; // RULE4
                result_next.dest = dtd_pkg::DTD_DEST_ACC_HIGH; // RULE4
                result_next.data = {ctx.flag_word[7:0], 8'h00}; // RULE4
            end
            else
                result_next.valid = 1'b0;

            if (result_next.memory_operand && result_next.form != dtd_pkg::DTD_FORM_LOAD_EA)
                mem_access = 1'b1;

            // Clock count table; faults add time that is not counted here
            case (result_next.form)
                dtd_pkg::DTD_FORM_RM_TO_SEG:
                    result_next.clocks = ctx.protected_mode
                        ? (is_mem ? `DTD_CLK_19 : `DTD_CLK_17)
                        : (is_mem ? `DTD_CLK_5 : `DTD_CLK_2); // RULE7
                dtd_pkg::DTD_FORM_SEG_TO_RM:
                    result_next.clocks = is_mem ? `DTD_CLK_3 : `DTD_CLK_2; // RULE1 RULE7
                dtd_pkg::DTD_FORM_PUSH_MEM:  result_next.clocks = `DTD_CLK_5;
                dtd_pkg::DTD_FORM_PUSH_REG:  result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_PUSH_SEG:  result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_PUSH_IMM:  result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_PUSHA:     result_next.clocks = `DTD_CLK_17;
                dtd_pkg::DTD_FORM_POP_MEM:   result_next.clocks = `DTD_CLK_5;
                dtd_pkg::DTD_FORM_POP_REG:   result_next.clocks = `DTD_CLK_5;
                dtd_pkg::DTD_FORM_POP_SEG:
                    result_next.clocks = ctx.protected_mode ? `DTD_CLK_20 : `DTD_CLK_5; // RULE7
                dtd_pkg::DTD_FORM_POPA:      result_next.clocks = `DTD_CLK_19;
                dtd_pkg::DTD_FORM_XCHG_RM:
                    result_next.clocks = is_mem ? `DTD_CLK_5 : `DTD_CLK_3; // RULE7
                dtd_pkg::DTD_FORM_XCHG_ACC:  result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_IN_FIXED:  result_next.clocks = `DTD_CLK_5;
                dtd_pkg::DTD_FORM_IN_VAR:    result_next.clocks = `DTD_CLK_5;
                dtd_pkg::DTD_FORM_OUT_FIXED: result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_OUT_VAR:   result_next.clocks = `DTD_CLK_3;
                dtd_pkg::DTD_FORM_TRANSLATE: result_next.clocks = `DTD_CLK_5; // RULE5
                dtd_pkg::DTD_FORM_LOAD_EA:   result_next.clocks = `DTD_CLK_3; // RULE6
                dtd_pkg::DTD_FORM_FAR_DATA,
                dtd_pkg::DTD_FORM_FAR_EXTRA:
                    result_next.clocks = ctx.protected_mode ? `DTD_CLK_21 : `DTD_CLK_7; // RULE2 RULE3
                dtd_pkg::DTD_FORM_FLAGS_ACC: result_next.clocks = `DTD_CLK_2; // RULE4
                default:                     result_next.clocks = 5'h00;
            endcase

            // Checks in priority order: encoding, memory, descriptor, port
            if (!result_next.valid)
                result_next.vector = `DTD_VEC_NONE;
            else if (bad_mod)
                result_next.vector = `DTD_VEC_UNDEF;
            else if (!ctx.protected_mode && mem_access && word_op
                     && ctx.ea_offset == `DTD_LAST_OFFSET)
                result_next.vector = `DTD_VEC_PROTECT; // RULE8
            else if (ctx.protected_mode && mem_access && ctx.stack_limit_fault)
                result_next.vector = `DTD_VEC_STACK; // RULE9
            else if (ctx.protected_mode && mem_access
                     && (ctx.limit_fault || ctx.access_fault))
                result_next.vector = `DTD_VEC_PROTECT; // RULE9
            else if (ctx.protected_mode && seg_load && !ctx.descriptor_present)
                result_next.vector = seg_dest_ss ? `DTD_VEC_STACK
                                                 : `DTD_VEC_NOT_PRES; // RULE10
            else if (ctx.protected_mode && io_form
                     && ctx.current_privilege_level > ctx.io_privilege_threshold)
                result_next.vector = `DTD_VEC_PROTECT; // RULE11
            else
                result_next.vector = `DTD_VEC_NONE;
            result_next.fault = (result_next.vector != `DTD_VEC_NONE);
            if (result_next.fault)
            begin
                // A faulting form commits nothing
                result_next.dest     = dtd_pkg::DTD_DEST_NONE;
                result_next.mem_read = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            result_reg <= '0;
        else
            result_reg <= result_next;
    end

    assign result = result_reg;

endmodule : dtd_decode
`default_nettype wire

/* hw/dtd_defs.svh */
// Purpose: Constants for the data transfer opcode decoder
// Assumes: Byte-wide opcode and operand byte inputs
// Notes:   Clock counts assume no wait states and no exceptions
`ifndef DTD_DEFS_SVH
`define DTD_DEFS_SVH

`define DTD_OP_RM_TO_SEG   8'h8E
`define DTD_OP_SEG_TO_RM   8'h8C
`define DTD_OP_GRP_FF      8'hFF
`define DTD_OP_POP_MEM     8'h8F
`define DTD_OP_PUSH_IMM    8'h68
`define DTD_OP_PUSHA       8'h60
`define DTD_OP_POPA        8'h61
`define DTD_OP_TRANSLATE   8'hD7
`define DTD_OP_LOAD_EA     8'h8D
`define DTD_OP_FAR_DATA    8'hC5
`define DTD_OP_FAR_EXTRA   8'hC4
`define DTD_OP_FLAGS_ACC   8'h9F
`define DTD_OP_XCHG_RM     7'h43
`define DTD_OP_IN_FIXED    7'h72
`define DTD_OP_IN_VAR      7'h76
`define DTD_OP_OUT_FIXED   7'h73
`define DTD_OP_OUT_VAR     7'h77
`define DTD_OP_PUSH_REG    5'h0A
`define DTD_OP_POP_REG     5'h0B
`define DTD_OP_XCHG_ACC    5'h12
`define DTD_MOD_REG        2'h3
`define DTD_REG_PUSH       3'h6
`define DTD_REG_POP        3'h0
`define DTD_SEG_SS         2'h2
`define DTD_SEG_CS         2'h1
`define DTD_LAST_OFFSET    16'hFFFF

`define DTD_VEC_NONE       8'h00
`define DTD_VEC_UNDEF      8'h06
`define DTD_VEC_NOT_PRES   8'h0B
`define DTD_VEC_STACK      8'h0C
`define DTD_VEC_PROTECT    8'h0D

`define DTD_CLK_2          5'h02
`define DTD_CLK_3          5'h03
`define DTD_CLK_5          5'h05
`define DTD_CLK_7          5'h07
`define DTD_CLK_17         5'h11
`define DTD_CLK_19         5'h13
`define DTD_CLK_20         5'h14
`define DTD_CLK_21         5'h15

`endif

/* hw/dtd_pkg.sv */
// Purpose: Types for the data transfer opcode decoder
// Assumes: Constants come from dtd_defs.svh
// Notes:   Form codes are internal only
package dtd_pkg;

    typedef enum logic [4:0] {
        DTD_FORM_NONE      = 5'h00,
        DTD_FORM_RM_TO_SEG = 5'h01,
        DTD_FORM_SEG_TO_RM = 5'h02,
        DTD_FORM_PUSH_MEM  = 5'h03,
        DTD_FORM_PUSH_REG  = 5'h04,
        DTD_FORM_PUSH_SEG  = 5'h05,
        DTD_FORM_PUSH_IMM  = 5'h06,
        DTD_FORM_PUSHA     = 5'h07,
        DTD_FORM_POP_MEM   = 5'h08,
        DTD_FORM_POP_REG   = 5'h09,
        DTD_FORM_POP_SEG   = 5'h0A,
        DTD_FORM_POPA      = 5'h0B,
        DTD_FORM_XCHG_RM   = 5'h0C,
        DTD_FORM_XCHG_ACC  = 5'h0D,
        DTD_FORM_IN_FIXED  = 5'h0E,
        DTD_FORM_IN_VAR    = 5'h0F,
        DTD_FORM_OUT_FIXED = 5'h10,
        DTD_FORM_OUT_VAR   = 5'h11,
        DTD_FORM_TRANSLATE = 5'h12,
        DTD_FORM_LOAD_EA   = 5'h13,
        DTD_FORM_FAR_DATA  = 5'h14,
        DTD_FORM_FAR_EXTRA = 5'h15,
        DTD_FORM_FLAGS_ACC = 5'h16
    } dtd_form_t;

    typedef enum logic [2:0] {
        DTD_DEST_NONE     = 3'h0,
        DTD_DEST_GENERAL  = 3'h1,
        DTD_DEST_ACC_LOW  = 3'h2,
        DTD_DEST_ACC_HIGH = 3'h3,
        DTD_DEST_SEGMENT  = 3'h4,
        DTD_DEST_MEMORY   = 3'h5
    } dtd_dest_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] operand;
    } dtd_instr_t;

    typedef struct packed {
        logic        protected_mode;
        logic [1:0]  current_privilege_level;
        logic [1:0]  io_privilege_threshold;
        logic [15:0] ea_offset;
        logic        limit_fault;
        logic        access_fault;
        logic        stack_limit_fault;
        logic        descriptor_present;
        logic [15:0] flag_word;
        logic [15:0] accumulator;
        logic [15:0] table_base;
    } dtd_ctx_t;

    typedef struct packed {
        logic        valid;
        dtd_form_t   form;
        logic        memory_operand;
        logic [4:0]  clocks;
        logic        fault;
        logic [7:0]  vector;
        dtd_dest_t   dest;
        logic [2:0]  dest_index;
        logic [15:0] data;
        logic        mem_read;
        logic [15:0] mem_offset;
    } dtd_result_t;

endpackage : dtd_pkg

/* verification/dtd_decode_chk.sv */
// Purpose: Concurrent checks on the data transfer decoder result
// Assumes: Result lands one cycle after the taking edge
// Notes:   Fault flags of the context only count in protected mode
`timescale 1ns/1ps
`default_nettype none

module dtd_decode_chk (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 instr_valid,
    input wire dtd_pkg::dtd_instr_t  instr,
    input wire dtd_pkg::dtd_ctx_t    ctx,
    input wire dtd_pkg::dtd_result_t result
);
    wire logic mem_op;
    wire logic prot;
    wire logic no_flag;
    assign mem_op  = instr.operand[7:6] != 2'h3;
    assign prot    = ctx.protected_mode;
    assign no_flag = !ctx.limit_fault && !ctx.access_fault && !ctx.stack_limit_fault;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_take(logic [7:0] op);
        instr_valid && instr.opcode == op;
    endsequence
    // Far pointer loads, memory operand only
    sequence s_far;
        instr_valid && instr.opcode[7:1] == 7'h62 && mem_op;
    endsequence
    AST_SEG_REG: assert property (s_take(8'h8C) ##0 !mem_op |=>
        result.valid && result.clocks == 5'h02) else $error("seg copy reg count");
    AST_SEG_MEM: assert property (s_take(8'h8C) ##0 mem_op |=>
        result.memory_operand && result.clocks == 5'h03) else $error("seg copy mem count");
    AST_CLK_TABLE: assert property (s_take(8'h8E) ##0 mem_op |=>
        result.clocks == ($past(prot) ? 5'h13 : 5'h05)) else $error("seg load count");
    AST_FAR_CLK: assert property (s_far |=>
        result.clocks == ($past(prot) ? 5'h15 : 5'h07)) else $error("far load count");
    AST_FAR_DEST: assert property (s_far ##0 (prot ? no_flag && ctx.descriptor_present
        : ctx.ea_offset != 16'hFFFF) |=> !result.fault && result.mem_read
        && result.dest_index == $past(instr.operand[5:3])) else $error("far load dest");
    AST_FLAGS_ACC: assert property (s_take(8'h9F) |=> !result.fault
        && result.data == {$past(ctx.flag_word[7:0]), 8'h00}) else $error("flags copy");
    AST_TRANSLATE: assert property (s_take(8'hD7) ##0 !prot |=>
        result.mem_read && result.clocks == 5'h05 && result.mem_offset
        == $past(ctx.table_base) + {8'h00, $past(ctx.accumulator[7:0])}) else $error("xlate");
    AST_LOAD_EA: assert property (s_take(8'h8D) ##0 mem_op |=> !result.fault
        && !result.mem_read && result.data == $past(ctx.ea_offset)) else $error("ea load");
    AST_OVERRUN: assert property (s_far ##0 !prot && ctx.ea_offset == 16'hFFFF |=>
        result.fault && result.vector == 8'h0D) else $error("overrun vector");
    AST_PROT_MEM: assert property (s_take(8'h8C) ##0 mem_op && prot |=>
        result.fault == !$past(no_flag) && (!result.fault || result.vector
        == ($past(ctx.stack_limit_fault) ? 8'h0C : 8'h0D))) else $error("prot mem vector");
    AST_NOT_PRES: assert property (s_far ##0 prot && no_flag && !ctx.descriptor_present
        |=> result.fault && result.vector == 8'h0B) else $error("not present vector");
    AST_PORT_PRIV: assert property (instr_valid && instr.opcode[7:4] == 4'hE
        && instr.opcode[2] && prot |=> result.fault == ($past(ctx.current_privilege_level)
        > $past(ctx.io_privilege_threshold))) else $error("port privilege");
endmodule : dtd_decode_chk

bind dtd_decode dtd_decode_chk u_chk (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .ctx(ctx), .result(result));

`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Directed bench for the data transfer decoder
// Assumes: Inputs change on the falling edge, result read one cycle later
// Notes:   Back to back offers inside each scenario
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                 clock;
    logic                 rst;
    logic                 instr_valid;
    dtd_pkg::dtd_instr_t  instr;
    dtd_pkg::dtd_ctx_t    ctx;
    dtd_pkg::dtd_result_t result;
    dtd_pkg::dtd_ctx_t    c;
    int                   mismatches;
    int                   compares;
    int                   cycles;

    dtd_decode dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .ctx(ctx), .result(result));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_of_test();
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // Ceiling well above the under one hundred cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic dtd_pkg::dtd_ctx_t base_ctx(input logic p);
        dtd_pkg::dtd_ctx_t x;
        x = '0;
        x.protected_mode     = p;
        x.descriptor_present = 1'b1;
        x.ea_offset          = 16'h0100;
        return x;
    endfunction : base_ctx

    // Called at a falling edge, returns at the next one with the answer settled
    task automatic issue(input logic [7:0] op, input logic [7:0] rm);
        instr_valid = 1'b1;
        instr       = {op, rm};
        ctx         = c;
        @(posedge clock);
        @(negedge clock);
    endtask : issue

    // Vector checked even when clean, so a stray vector cannot hide
    task automatic core(input logic [4:0] clk, input logic flt, input logic [7:0] vec);
        check(result.valid, 1'b1);
        check(result.clocks, clk);
        check(result.fault, flt);
        check(result.vector, vec);
    endtask : core

    // Clock counts of the stack, exchange and segment load forms, both modes
    task automatic t_table();
        logic [31:0] rows [15] = '{32'h8EC0_0211, 32'h8E00_0513, 32'hFF30_0505,
            32'h5000_0303, 32'h0600_0303, 32'h6A00_0303, 32'h6800_0303, 32'h6000_1111,
            32'h8F00_0505, 32'h5800_0505, 32'h1F00_0514, 32'h6100_1313, 32'h87C0_0303,
            32'h8700_0505, 32'h9000_0303};
        for (int m = 0; m < 2; m++)
        begin
            for (int i = 0; i < 15; i++)
            begin
                c = base_ctx(m[0]);
                issue(rows[i][31:24], rows[i][23:16]);
                core(m ? rows[i][4:0] : rows[i][12:8], 1'b0, 8'h00);
            end
        end
    endtask : t_table

    task automatic t_seg_far();
        for (int m = 0; m < 2; m++)
        begin
            c = base_ctx(m[0]);
            issue(8'h8C, 8'hC8);
            core(5'h02, 1'b0, 8'h00);
            issue(8'h8C, 8'h08);
            core(5'h03, 1'b0, 8'h00);
            check(result.memory_operand, 1'b1);
            issue(8'hC5, 8'h1E);
            core(m ? 5'h15 : 5'h07, 1'b0, 8'h00);
            check(result.form, dtd_pkg::DTD_FORM_FAR_DATA);
            check(result.dest_index, 3'h3);
            check(result.dest, dtd_pkg::DTD_DEST_GENERAL);
            check(result.mem_read, 1'b1);
            issue(8'hC4, 8'h2E);
            core(m ? 5'h15 : 5'h07, 1'b0, 8'h00);
            check(result.form, dtd_pkg::DTD_FORM_FAR_EXTRA);
            check(result.dest_index, 3'h5);
            issue(8'hC4, 8'hD8);
            core(m ? 5'h15 : 5'h07, 1'b1, 8'h06);
        end
    endtask : t_seg_far

    task automatic t_single_byte();
        c = base_ctx(1'b1);
        c.flag_word   = 16'h12D5;
        c.limit_fault = 1'b1;
        issue(8'h9F, 8'h00);
        core(5'h02, 1'b0, 8'h00);
        check(result.dest, dtd_pkg::DTD_DEST_ACC_HIGH);
        check(result.data, 16'hD500);
        c = base_ctx(1'b0);
        c.table_base  = 16'hFFF0;
        c.accumulator = 16'h3420;
        issue(8'hD7, 8'h00);
        core(5'h05, 1'b0, 8'h00);
        check(result.mem_offset, 16'h0010);
        check(result.mem_read, 1'b1);
        c.protected_mode = 1'b1;
        c.access_fault   = 1'b1;
        issue(8'hD7, 8'h00);
        core(5'h05, 1'b1, 8'h0D);
        c.ea_offset         = 16'h1234;
        c.stack_limit_fault = 1'b1;
        issue(8'h8D, 8'h5E);
        core(5'h03, 1'b0, 8'h00);
        check(result.data, 16'h1234);
        check(result.mem_read, 1'b0);
    endtask : t_single_byte

    // Word operand at the last offset faults, one below does not
    task automatic t_faults();
        c = base_ctx(1'b0);
        c.ea_offset = 16'hFFFF;
        issue(8'hC5, 8'h1E);
        core(5'h07, 1'b1, 8'h0D);
        check(result.mem_read, 1'b0);
        check(result.dest, dtd_pkg::DTD_DEST_NONE);
        c.ea_offset = 16'hFFFE;
        issue(8'hC5, 8'h1E);
        core(5'h07, 1'b0, 8'h00);
        // Byte exchange at the last offset stays clean, word form overruns
        c.ea_offset = 16'hFFFF;
        issue(8'h86, 8'h00);
        core(5'h05, 1'b0, 8'h00);
        issue(8'h87, 8'h00);
        core(5'h05, 1'b1, 8'h0D);
        c = base_ctx(1'b1);
        c.stack_limit_fault = 1'b1;
        c.limit_fault       = 1'b1;
        issue(8'h8C, 8'h08);
        core(5'h03, 1'b1, 8'h0C);
        c.stack_limit_fault = 1'b0;
        issue(8'h8C, 8'h08);
        core(5'h03, 1'b1, 8'h0D);
        c = base_ctx(1'b1);
        c.descriptor_present = 1'b0;
        issue(8'hC4, 8'h1E);
        core(5'h15, 1'b1, 8'h0B);
        issue(8'h8E, 8'h10);
        core(5'h13, 1'b1, 8'h0C);
        issue(8'h8E, 8'h18);
        core(5'h13, 1'b1, 8'h0B);
    endtask : t_faults

    task automatic t_ports();
        logic [7:0] ops [8] = '{8'hE4, 8'hE5, 8'hEC, 8'hED, 8'hE6, 8'hE7, 8'hEE, 8'hEF};
        for (int i = 0; i < 8; i++)
        begin
            c = base_ctx(1'b1);
            c.current_privilege_level = 2'h3;
            c.io_privilege_threshold  = 2'h2;
            issue(ops[i], 8'h40);
            core(i < 4 ? 5'h05 : 5'h03, 1'b1, 8'h0D);
            c.current_privilege_level = 2'h2;
            issue(ops[i], 8'h40);
            check(result.fault, 1'b0);
            c = base_ctx(1'b0);
            c.current_privilege_level = 2'h3;
            issue(ops[i], 8'h40);
            check(result.fault, 1'b0);
        end
        issue(8'h0F, 8'h00);
        check(result.valid, 1'b0);
        instr_valid = 1'b0;
        @(posedge clock);
        @(negedge clock);
        check(result.valid, 1'b0);
    endtask : t_ports

    initial
    begin
        rst         = 1'b1;
        instr_valid = 1'b0;
        instr       = '0;
        ctx         = '0;
        c           = '0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check(result.valid, 1'b0);
        t_seg_far();
        t_single_byte();
        t_faults();
        t_table();
        t_ports();
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
